// ### verilog/tscw_pkg.sv
// Package for the terminal status control word block.
// Assumes a single 250 MHz system clock and an asynchronous active-high reset.
package tscw_pkg;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W          = 16;
  localparam int unsigned BIT_SCREEN      = 15;
  localparam int unsigned BIT_HIST_PRINT  = 5;
  localparam int unsigned BIT_RPT_PRINT   = 4;
  localparam logic [15:0] CTRL_USED_MASK  = 16'h8030;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic        SCREEN_RESET    = 1'b1;

  // ----------------------------------------------------------------
  // Notify word layout
  // ----------------------------------------------------------------
  localparam int unsigned BIT_NUM_STROBE  = 11;
  localparam logic [11:0] ENTRY_RESET     = 12'h000;
  localparam int unsigned DIGITS          = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } tscw_sample_t;

  typedef struct packed {
    logic       strobe;
    logic [11:0] entry_bcd;
  } tscw_notify_t;

endpackage

// ### verilog/tscw_bin2bcd.sv
// Combinational binary to three-digit BCD converter.
// Assumes the input is below 1000; larger values saturate to 999.
`timescale 1ns/1ps
module tscw_bin2bcd
(
  // Value in
  input  wire logic [9:0]  bin,
  // Digits out
  output      logic [11:0] bcd
);
  import tscw_pkg::*;

  logic [9:0] sat;
  logic [3:0] hund;
  logic [3:0] tens;
  logic [3:0] ones;

  always_comb
  begin
    sat  = (bin > 10'd999) ? 10'd999 : bin;
    hund = 4'(sat / 10'd100);
    tens = 4'((sat % 10'd100) / 10'd10);
    ones = 4'(sat % 10'd10);
    bcd  = {hund, tens, ones};
  end

endmodule

// ### verilog/tscw_top.sv
// Terminal status control word: edge-acting control bits and numeral notify.
// Assumes the shared control word arrives from the serial link logic with a
// sample strobe in this clock domain, and that a key input is a raw pin.
`timescale 1ns/1ps

// Overview of operation
// - Screen bit 0 turns backlight and screen off
// - Relight on screen bit set or key press
// - History bit rising prints history exactly once
// - Reprint history only after clear then set
// - Report bit rising reads words, prints once
// - Reprint report only after clear then set
// - Device never writes the control word back
// - Entry number written as three BCD digits
// - Strobe returns to 0 once delivered
// - No action at start-up, only on change
module tscw_top
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  // Control word samples from the controller memory
  input  wire tscw_pkg::tscw_sample_t CTRL_SAMPLE,
  // Operator key, raw pin
  input  wire logic                 KEY_PRESS,
  // Numeral entry event from the terminal
  input  wire logic                 NUM_SET,
  input  wire logic [9:0]           NUM_ENTRY,
  input  wire logic                 NOTIFY_DONE,
  // Display outputs
  output      logic                 BACKLIGHT_ON,
  output      logic                 SCREEN_ON,
  // Print requests, one-cycle pulses
  output      logic                 HIST_PRINT_REQ,
  output      logic                 RPT_PRINT_REQ,
  // Notify word fields
  output      tscw_pkg::tscw_notify_t NOTIFY
);
  import tscw_pkg::*;

  // ----------------------------------------------------------------
  // Key synchroniser
  // ----------------------------------------------------------------
  logic key_meta_ff;
  logic key_sync_ff;
  logic key_prev_ff;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      key_meta_ff <= 1'b0;
      key_sync_ff <= 1'b0;
      key_prev_ff <= 1'b0;
    end
    else
    begin
      key_meta_ff <= KEY_PRESS;
      key_sync_ff <= key_meta_ff;
      key_prev_ff <= key_sync_ff;
    end
  end

  logic key_rise;
  assign key_rise = key_sync_ff & ~key_prev_ff;

  // ----------------------------------------------------------------
  // Sample history and edge detection
  // ----------------------------------------------------------------
  // First sample only primes the copy, so start-up never acts.
  logic        primed_ff;
  logic [15:0] last_ff;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      primed_ff <= 1'b0;
      last_ff   <= CTRL_RESET;
    end
    else if (CTRL_SAMPLE.valid)
    begin
      primed_ff <= 1'b1;
      last_ff   <= CTRL_SAMPLE.word;
    end
  end

  logic [15:0] rise_bits;
  logic [15:0] fall_bits;
  logic        act;

  always_comb
  begin
    act       = CTRL_SAMPLE.valid & primed_ff;
    rise_bits = act ? (CTRL_SAMPLE.word & ~last_ff & CTRL_USED_MASK)
                    : 16'h0000;
    fall_bits = act ? (~CTRL_SAMPLE.word & last_ff & CTRL_USED_MASK)
                    : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Screen and backlight
  // ----------------------------------------------------------------
  // The control word is input only; screen state may drift from bit 15.
  logic screen_ff;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      screen_ff <= SCREEN_RESET;
    else if (rise_bits[BIT_SCREEN] || key_rise)
      screen_ff <= 1'b1;
    else if (fall_bits[BIT_SCREEN])
      screen_ff <= 1'b0;
  end

  assign BACKLIGHT_ON = screen_ff;
  assign SCREEN_ON    = screen_ff;

  // ----------------------------------------------------------------
  // Print requests
  // ----------------------------------------------------------------
  logic hist_req_ff;
  logic rpt_req_ff;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      hist_req_ff <= 1'b0;
      rpt_req_ff  <= 1'b0;
    end
    else
    begin
      hist_req_ff <= rise_bits[BIT_HIST_PRINT];
      rpt_req_ff  <= rise_bits[BIT_RPT_PRINT];
    end
  end

  assign HIST_PRINT_REQ = hist_req_ff;
  assign RPT_PRINT_REQ  = rpt_req_ff;

  // ----------------------------------------------------------------
  // Numeral entry notify
  // ----------------------------------------------------------------
  logic [11:0] entry_bcd;
  logic        strobe_ff;
  logic [11:0] entry_ff;

  tscw_bin2bcd u_bcd
  (
    .bin (NUM_ENTRY),
    .bcd (entry_bcd)
  );

  // A new entry wins over a delivery clear in the same cycle.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      strobe_ff <= 1'b0;
      entry_ff  <= ENTRY_RESET;
    end
    else if (NUM_SET)
    begin
      strobe_ff <= 1'b1;
      entry_ff  <= entry_bcd;
    end
    else if (NOTIFY_DONE)
      strobe_ff <= 1'b0;
  end

  assign NOTIFY.strobe    = strobe_ff;
  assign NOTIFY.entry_bcd = entry_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hist_rise;
    CTRL_SAMPLE.valid && primed_ff && CTRL_SAMPLE.word[5] && !last_ff[5];
  endsequence

  sequence s_rpt_rise;
    CTRL_SAMPLE.valid && primed_ff && CTRL_SAMPLE.word[4] && !last_ff[4];
  endsequence

  a_screen_off_fall: assert property (@(posedge CLK) disable iff (RESET)
    (act && !CTRL_SAMPLE.word[15] && last_ff[15] && !key_rise) |=> !BACKLIGHT_ON)
    else $error("backlight not off after screen bit cleared");

  a_screen_relight: assert property (@(posedge CLK) disable iff (RESET)
    (key_rise || (act && CTRL_SAMPLE.word[15] && !last_ff[15])) |=> BACKLIGHT_ON)
    else $error("backlight not relit");

  a_hist_once: assert property (@(posedge CLK) disable iff (RESET)
    s_hist_rise |=> HIST_PRINT_REQ ##1 !HIST_PRINT_REQ)
    else $error("history print not issued once");

  a_hist_no_repeat: assert property (@(posedge CLK) disable iff (RESET)
    HIST_PRINT_REQ |-> $past(act) && $past(CTRL_SAMPLE.word[5]) && !$past(last_ff[5]))
    else $error("history print without rising bit");

  a_rpt_once: assert property (@(posedge CLK) disable iff (RESET)
    s_rpt_rise |=> RPT_PRINT_REQ ##1 !RPT_PRINT_REQ)
    else $error("report print missing");

  a_rpt_no_repeat: assert property (@(posedge CLK) disable iff (RESET)
    RPT_PRINT_REQ |-> $past(act) && $past(CTRL_SAMPLE.word[4]) && !$past(last_ff[4]))
    else $error("report print without rising bit");

  a_startup_quiet: assert property (@(posedge CLK) disable iff (RESET)
    (CTRL_SAMPLE.valid && !primed_ff) |=> !HIST_PRINT_REQ && !RPT_PRINT_REQ)
    else $error("action taken on first sample");

  a_unused_quiet: assert property (@(posedge CLK) disable iff (RESET)
    (act && ((CTRL_SAMPLE.word ^ last_ff) & CTRL_USED_MASK) == 16'h0000)
      |=> !HIST_PRINT_REQ && !RPT_PRINT_REQ && ($stable(BACKLIGHT_ON) || $past(key_rise)))
    else $error("unused bit caused action");

  a_strobe_set: assert property (@(posedge CLK) disable iff (RESET)
    NUM_SET |=> NOTIFY.strobe && NOTIFY.entry_bcd == $past(entry_bcd))
    else $error("strobe or entry not captured");

  a_strobe_clear: assert property (@(posedge CLK) disable iff (RESET)
    (NOTIFY_DONE && !NUM_SET) |=> !NOTIFY.strobe)
    else $error("strobe not returned to zero");

endmodule

// ### verification/tscw_ctrl_model.sv
// Controller model: owns the control word, reads the notify entry word.
// Assumes the bench asks for a word write with a one-cycle wr_go.
`timescale 1ns/1ps
module tscw_ctrl_model
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Write requests from the bench
  input  wire logic                   wr_go,
  input  wire logic [15:0]            wr_word,
  // Terminal side
  input  wire tscw_pkg::tscw_notify_t notify,
  output      tscw_pkg::tscw_sample_t sample,
  output      logic                   done,
  output      logic [11:0]            entry_seen
);
  import tscw_pkg::*;
  logic strobe_ff;

  // Whole word rewritten, so a reprint needs an explicit clear first
  always_ff @(posedge clk or posedge reset)
    if (reset)
      sample <= '0;
    else
      sample <= '{valid: wr_go, word: wr_go ? wr_word : sample.word};

  // Entry word read only on the strobe's rising edge, acked next cycle
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      strobe_ff  <= 1'b0;
      done       <= 1'b0;
      entry_seen <= 12'h000;
    end
    else
    begin
      strobe_ff <= notify.strobe;
      done      <= notify.strobe && !strobe_ff;
      if (notify.strobe && !strobe_ff)
        entry_seen <= notify.entry_bcd;
    end
endmodule

// ### verification/tb.sv
// Testbench for the terminal status control word block.
// Assumes the controller model drives samples and acks the notify strobe.
`timescale 1ns/1ps
module tb;
  logic                   CLK = 1'b0;
  logic                   RESET = 1'b1;
  logic                   go = 1'b0;
  logic [15:0]            word = 16'h0000;
  logic                   key = 1'b0;
  logic                   num_set = 1'b0;
  logic [9:0]             num = 10'h000;
  logic                   done, bl, scr, hreq, rreq;
  logic [11:0]            seen_entry;
  tscw_pkg::tscw_sample_t smp;
  tscw_pkg::tscw_notify_t ntf;
  int                     err_total = 0;
  int                     checked = 0;

  always #2 CLK = ~CLK;

  tscw_ctrl_model plc (.clk(CLK), .reset(RESET), .wr_go(go), .wr_word(word), .notify(ntf),
    .sample(smp), .done(done), .entry_seen(seen_entry));
  tscw_top dut (.CLK(CLK), .RESET(RESET), .CTRL_SAMPLE(smp), .KEY_PRESS(key),
    .NUM_SET(num_set), .NUM_ENTRY(num), .NOTIFY_DONE(done), .BACKLIGHT_ON(bl),
    .SCREEN_ON(scr), .HIST_PRINT_REQ(hreq), .RPT_PRINT_REQ(rreq), .NOTIFY(ntf));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One controller write; answer lands exactly one cycle after the sample
  task automatic wr(input logic [15:0] w, input logic h, input logic r, input logic on);
    @(posedge CLK) go <= 1'b1;
    word <= w;
    @(posedge CLK) go <= 1'b0;
    @(posedge CLK) #1;
    chk("hist_req", hreq, h);
    chk("rpt_req", rreq, r);
    chk("backlight", bl, on);
    chk("screen", scr, on);
    @(posedge CLK) #1;
    chk("hist_pulse", hreq, 1'b0);
    chk("rpt_pulse", rreq, 1'b0);
  endtask

  task automatic t_print();
    chk("bl_rst", bl, 1'b1);
    chk("strobe_rst", ntf.strobe, 1'b0);
    wr(16'h8030, 1'b0, 1'b0, 1'b1);
    wr(16'h8030, 1'b0, 1'b0, 1'b1);
    wr(16'h8000, 1'b0, 1'b0, 1'b1);
    wr(16'h8020, 1'b1, 1'b0, 1'b1);
    wr(16'h8010, 1'b0, 1'b1, 1'b1);
    wr(16'h8030, 1'b1, 1'b0, 1'b1);
    wr(16'h8000, 1'b0, 1'b0, 1'b1);
    wr(16'h8030, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_screen();
    wr(16'h0000, 1'b0, 1'b0, 1'b0);
    @(posedge CLK) key <= 1'b1;
    repeat (4) @(posedge CLK);
    #1 chk("key_relight", bl, 1'b1);
    @(posedge CLK) key <= 1'b0;
    wr(16'h8000, 1'b0, 1'b0, 1'b1);
    wr(16'h0000, 1'b0, 1'b0, 1'b0);
    wr(16'h8000, 1'b0, 1'b0, 1'b1);
    // Unused bits toggled with every used bit held
    wr(16'hffcf, 1'b0, 1'b0, 1'b1);
    wr(16'h8000, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic t_notify(input logic [9:0] n, input logic [11:0] bcd);
    @(posedge CLK) num_set <= 1'b1;
    num <= n;
    @(posedge CLK) num_set <= 1'b0;
    #1 chk("strobe_set", ntf.strobe, 1'b1);
    chk("entry_bcd", ntf.entry_bcd, bcd);
    repeat (3) @(posedge CLK);
    #1 chk("strobe_clr", ntf.strobe, 1'b0);
    chk("plc_entry", seen_entry, bcd);
  endtask

  // Delivery ack meets a new entry; the new entry must win
  task automatic t_collide();
    @(posedge CLK) num_set <= 1'b1;
    num <= 10'd5;
    @(posedge CLK) num_set <= 1'b0;
    @(posedge CLK) num_set <= 1'b1;
    num <= 10'd6;
    @(posedge CLK) num_set <= 1'b0;
    #1 chk("collide_strobe", ntf.strobe, 1'b1);
    chk("collide_entry", ntf.entry_bcd, 12'h006);
    @(posedge CLK) #1;
    chk("collide_hold", ntf.strobe, 1'b1);
    chk("collide_plc", seen_entry, 12'h005);
  endtask

  // Mid-run reset: state cleared, first sample only primes again
  task automatic t_reset();
    @(posedge CLK) RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    #1 chk("strobe_rst2", ntf.strobe, 1'b0);
    chk("bl_rst2", bl, 1'b1);
    wr(16'h8030, 1'b0, 1'b0, 1'b1);
    wr(16'h8020, 1'b0, 1'b0, 1'b1);
    wr(16'h8030, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic stop_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    t_print();
    t_screen();
    t_notify(10'd3, 12'h003);
    t_notify(10'd427, 12'h427);
    t_notify(10'd1023, 12'h999);
    t_collide();
    t_reset();
    stop_test();
  end

  // Run needs about 110 cycles; this limit is far beyond that
  initial
  begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule
